// ### inc/sts_pkg.sv
// Constants and types shared by the status and trigger sequencer.
// Assumes a single 40 MHz system clock and synchronous command strobes.
package sts_pkg;
  localparam int CLK_PERIOD_NS = 25;
  localparam int DELAY_UNIT_NS = 1000;
  localparam int DELAY_UNIT_CYC = (DELAY_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int BIT_SETTLING   = 1;
  localparam int BIT_RANGING    = 2;
  localparam int BIT_MEASURING  = 4;
  localparam int BIT_WAIT_TRIG  = 5;
  localparam int BIT_CORRECTING = 7;
  localparam int BIT_FIRST_FULL  = 8;
  localparam int BIT_SECOND_FULL = 9;

  localparam logic [15:0] OPER_IMPL_MASK    = 16'h03B6;
  localparam logic [15:0] RISE_EDGE_MASK    = 16'h0300;
  localparam logic [15:0] OPER_COND_RESET   = 16'h0000;
  localparam logic [15:0] OPER_EVENT_RESET  = 16'h0000;
  localparam logic [15:0] OPER_ENABLE_RESET = 16'h0000;
  localparam logic [15:0] QUES_STATUS_VALUE = 16'h0000;
  localparam logic [15:0] TRIG_DELAY_RESET  = 16'h0000;
  localparam logic        INIT_CONT_RESET   = 1'b0;

  localparam int EXP_W = 11;
  localparam int FRAC_W = 52;
  localparam int BIN_VALUE_BYTES = 8;
  localparam int BUF_BYTES = 16;

  localparam logic [7:0] CH_HASH  = 8'h23;
  localparam logic [7:0] CH_ZERO  = 8'h30;
  localparam logic [7:0] CH_COMMA = 8'h2C;
  localparam logic [7:0] CH_POINT = 8'h2E;
  localparam logic [7:0] CH_MINUS = 8'h2D;
  localparam logic [7:0] CH_PLUS  = 8'h2B;
  localparam logic [7:0] CH_EXP   = 8'h45;
  localparam logic [7:0] CH_NL    = 8'h0A;

  typedef enum logic [1:0] {SRC_INTERNAL = 2'h0, SRC_BUS = 2'h1, SRC_EXTERNAL = 2'h2} sts_src_t;
  typedef enum logic [1:0] {FORM_NR1 = 2'h0, FORM_NR2 = 2'h1, FORM_NR3 = 2'h2} sts_form_t;
  typedef enum logic [4:0] {
    T_IDLE = 5'h01, T_INIT = 5'h02, T_DETECT = 5'h04, T_DELAY = 5'h08, T_SEQ = 5'h10
  } sts_tstate_t;
  typedef enum logic [2:0] {F_IDLE = 3'h1, F_WAIT = 3'h2, F_EMIT = 3'h4} sts_fstate_t;
endpackage

// ### hw/sts_status_group.sv
// Operation status group: condition, transition filter, event and enable.
// Assumes condition inputs are synchronous to clk_sys_i.
`timescale 1ns/1ps
module sts_status_group
  import sts_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  input  wire logic [15:0] cond_i,
  input  wire logic        enable_wr_i,
  input  wire logic [15:0] enable_data_i,
  input  wire logic        event_rd_i,
  output logic      [15:0] cond_o,
  output logic      [15:0] event_o,
  output logic      [15:0] enable_o,
  output logic             summary_o
);
  logic [15:0] cond_r, cond_nxt, event_r, event_nxt, enable_r, enable_nxt, set_v;
  logic        summary_r, summary_nxt;

  always_comb begin
    cond_nxt = cond_i & OPER_IMPL_MASK;
    set_v = (cond_r & ~cond_nxt & ~RISE_EDGE_MASK)
          | (~cond_r & cond_nxt & RISE_EDGE_MASK);
    // Read returns the latched bits and clears them; a new set wins
    event_nxt = (event_r & ~(event_rd_i ? event_r : 16'h0000)) | set_v;
    enable_nxt = enable_wr_i ? enable_data_i : enable_r;
    summary_nxt = |(event_nxt & enable_nxt);
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      cond_r    <= OPER_COND_RESET;
      event_r   <= OPER_EVENT_RESET;
      enable_r  <= OPER_ENABLE_RESET;
      summary_r <= 1'b0;
    end else begin
      cond_r    <= cond_nxt;
      event_r   <= event_nxt;
      enable_r  <= enable_nxt;
      summary_r <= summary_nxt;
    end
  end

  assign cond_o    = cond_r;
  assign event_o   = event_r;
  assign enable_o  = enable_r;
  assign summary_o = summary_r;
endmodule

// ### hw/sts_sequencer.sv
// Status reporting, trigger sequencer and response formatter core.
// Assumes command strobes are one-cycle pulses synchronous to clk_sys_i.
`timescale 1ns/1ps
module sts_sequencer
  import sts_pkg::*;
(
  input  wire logic              clk_sys_i,
  input  wire logic              reset_i,
  input  wire logic              cmd_abort_i,
  input  wire logic              cmd_reset_i,
  input  wire logic              cmd_init_imm_i,
  input  wire logic              cmd_init_cont_wr_i,
  input  wire logic              cmd_init_cont_val_i,
  input  wire logic              cmd_trig_imm_i,
  input  wire logic              cmd_bus_trig_i,
  input  wire logic              cmd_src_wr_i,
  input  wire logic       [1:0]  cmd_src_val_i,
  input  wire logic              cmd_delay_wr_i,
  input  wire logic       [15:0] cmd_delay_val_i,
  input  wire logic              ext_trig_i,
  input  wire logic              meas_done_i,
  input  wire logic              correcting_i,
  input  wire logic              ranging_i,
  input  wire logic              settling_i,
  input  wire logic              first_result_buffer_full_i,
  input  wire logic              second_result_buffer_full_i,
  input  wire logic              oper_enable_wr_i,
  input  wire logic       [15:0] oper_enable_data_i,
  input  wire logic              oper_event_rd_i,
  input  wire logic              fmt_start_i,
  input  wire logic              fmt_binary_i,
  input  wire logic       [1:0]  fmt_form_i,
  input  wire logic       [7:0]  fmt_count_i,
  input  wire logic              val_valid_i,
  input  wire logic              val_sign_i,
  input  wire logic       [10:0] val_exp_i,
  input  wire logic       [51:0] val_frac_i,
  input  wire logic       [23:0] val_mant_i,
  input  wire logic signed [7:0] val_dexp_i,
  input  wire logic              out_ready_i,
  output logic                   val_ready_o,
  output logic            [7:0]  out_data_o,
  output logic                   out_valid_o,
  output logic                   out_end_o,
  output logic                   fmt_busy_o,
  output logic                   meas_start_o,
  output logic            [15:0] operation_condition_o,
  output logic            [15:0] operation_event_o,
  output logic            [15:0] operation_enable_o,
  output logic            [15:0] questionable_status_o,
  output logic                   stb_oper_summary_o,
  output logic                   stb_ques_summary_o
);
  function automatic logic [31:0] to_bcd(input logic [23:0] v);
    logic [23:0] r;
    logic [31:0] d;
    r = v;
    d = 32'h0;
    for (int i = 0; i < 8; i++) begin
      d[i*4 +: 4] = 4'(r % 24'd10);
      r = r / 24'd10;
    end
    return d;
  endfunction

  function automatic int digit_count(input logic [31:0] d);
    int c;
    c = 1;
    for (int i = 0; i < 8; i++) begin
      if (d[i*4 +: 4] != 4'h0) c = i + 1;
    end
    return c;
  endfunction

  // ---- Configuration and trigger sequencer
  sts_tstate_t ts_r, ts_nxt;
  logic        down_r, down_nxt, cont_r, cont_nxt, start_r, start_nxt, ext_prev_r;
  sts_src_t    src_r, src_nxt;
  logic [15:0] delay_r, delay_nxt, dcnt_r, dcnt_nxt;
  logic [5:0]  div_r, div_nxt;
  logic        tick, src_evt;
  logic [15:0] cond_v;

  always_comb begin
    ts_nxt = ts_r;
    down_nxt = down_r;
    cont_nxt = cont_r;
    src_nxt = src_r;
    delay_nxt = delay_r;
    dcnt_nxt = dcnt_r;
    tick = (div_r == 6'(DELAY_UNIT_CYC - 1));
    div_nxt = tick ? 6'h00 : div_r + 6'h01;
    if (cmd_init_cont_wr_i) cont_nxt = cmd_init_cont_val_i;
    if (cmd_src_wr_i && cmd_src_val_i != 2'h3) src_nxt = sts_src_t'(cmd_src_val_i);
    if (cmd_delay_wr_i) delay_nxt = cmd_delay_val_i;
    unique case (src_r)
      SRC_BUS:      src_evt = cmd_bus_trig_i;
      SRC_EXTERNAL: src_evt = ext_trig_i & ~ext_prev_r;
      default:      src_evt = 1'b1;
    endcase
    unique case (ts_r)
      T_IDLE: begin
        if (cmd_init_imm_i || cont_r) begin
          ts_nxt = T_INIT;
          down_nxt = 1'b1;
        end
      end
      T_INIT: begin
        // Downward passes through; upward re-arms only when continuous
        ts_nxt = (down_r || cont_r) ? T_DETECT : T_IDLE;
        down_nxt = 1'b1;
      end
      T_DETECT: begin
        if (cmd_trig_imm_i) ts_nxt = T_SEQ;
        else if (src_evt) begin
          ts_nxt = (delay_r == 16'h0000) ? T_SEQ : T_DELAY;
          dcnt_nxt = delay_r;
          div_nxt = 6'h00;
        end
      end
      T_DELAY: begin
        if (cmd_trig_imm_i || dcnt_r == 16'h0000) ts_nxt = T_SEQ;
        else if (tick) dcnt_nxt = dcnt_r - 16'h0001;
      end
      T_SEQ: begin
        if (meas_done_i) begin
          ts_nxt = T_INIT;
          down_nxt = 1'b0;
        end
      end
      default: ts_nxt = T_IDLE;
    endcase
    if (cmd_abort_i || cmd_reset_i) begin
      ts_nxt = T_IDLE;
      down_nxt = 1'b1;
    end
    if (cmd_reset_i) begin
      cont_nxt = INIT_CONT_RESET;
      delay_nxt = TRIG_DELAY_RESET;
    end
    start_nxt = (ts_nxt == T_SEQ) && (ts_r != T_SEQ);
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      ts_r       <= T_IDLE;
      down_r     <= 1'b1;
      cont_r     <= INIT_CONT_RESET;
      src_r      <= SRC_INTERNAL;
      delay_r    <= TRIG_DELAY_RESET;
      dcnt_r     <= 16'h0000;
      div_r      <= 6'h00;
      start_r    <= 1'b0;
      ext_prev_r <= 1'b0;
    end else begin
      ts_r       <= ts_nxt;
      down_r     <= down_nxt;
      cont_r     <= cont_nxt;
      src_r      <= src_nxt;
      delay_r    <= delay_nxt;
      dcnt_r     <= dcnt_nxt;
      div_r      <= div_nxt;
      start_r    <= start_nxt;
      ext_prev_r <= ext_trig_i;
    end
  end

  assign meas_start_o = start_r;

  // ---- Status groups
  always_comb begin
    cond_v = 16'h0000;
    cond_v[BIT_SECOND_FULL] = second_result_buffer_full_i;
    cond_v[BIT_FIRST_FULL]  = first_result_buffer_full_i;
    cond_v[BIT_CORRECTING] = correcting_i;
    cond_v[BIT_WAIT_TRIG]  = (ts_r == T_DETECT);
    cond_v[BIT_MEASURING]  = (ts_r == T_SEQ);
    cond_v[BIT_RANGING]    = ranging_i;
    cond_v[BIT_SETTLING]   = settling_i;
  end

  sts_status_group u_oper (
    .clk_sys_i     (clk_sys_i),
    .reset_i       (reset_i),
    .cond_i        (cond_v),
    .enable_wr_i   (oper_enable_wr_i),
    .enable_data_i (oper_enable_data_i),
    .event_rd_i    (oper_event_rd_i),
    .cond_o        (operation_condition_o),
    .event_o       (operation_event_o),
    .enable_o      (operation_enable_o),
    .summary_o     (stb_oper_summary_o)
  );

  assign questionable_status_o = QUES_STATUS_VALUE;
  assign stb_ques_summary_o = 1'b0;

  // ---- Response formatter
  sts_fstate_t fs_r, fs_nxt;
  logic [7:0]  buf_r [BUF_BYTES];
  logic [7:0]  buf_nxt [BUF_BYTES];
  logic [4:0]  len_r, len_nxt;
  logic [3:0]  idx_r, idx_nxt;
  logic [7:0]  left_r, left_nxt;
  logic        bin_r, bin_nxt, last_r, last_nxt;
  sts_form_t   form_r, form_nxt;
  logic        do_hdr, do_val, do_term;
  logic [31:0] bcd;
  logic [63:0] word;
  int          n, nd, p, x;

  always_comb begin
    fs_nxt = fs_r;
    buf_nxt = buf_r;
    len_nxt = len_r;
    idx_nxt = idx_r;
    left_nxt = left_r;
    bin_nxt = bin_r;
    form_nxt = form_r;
    last_nxt = last_r;
    do_hdr = 1'b0;
    do_val = 1'b0;
    do_term = 1'b0;
    bcd = 32'h0;
    word = 64'h0;
    n = 0;
    nd = 1;
    p = 0;
    x = 0;
    unique case (fs_r)
      F_IDLE: begin
        if (fmt_start_i) begin
          bin_nxt = fmt_binary_i;
          form_nxt = (fmt_form_i == 2'h3) ? FORM_NR3 : sts_form_t'(fmt_form_i);
          left_nxt = fmt_count_i;
          if (fmt_binary_i) do_hdr = 1'b1;
          else if (fmt_count_i == 8'h00) do_term = 1'b1;
          else fs_nxt = F_WAIT;
        end
      end
      F_WAIT: begin
        if (val_valid_i) begin
          do_val = 1'b1;
          left_nxt = left_r - 8'h01;
        end
      end
      F_EMIT: begin
        if (out_ready_i) begin
          if ({1'b0, idx_r} == len_r - 5'h01) begin
            idx_nxt = 4'h0;
            if (last_r) begin
              fs_nxt = F_IDLE;
              last_nxt = 1'b0;
            end else if (left_r != 8'h00) fs_nxt = F_WAIT;
            else do_term = 1'b1;
          end else idx_nxt = idx_r + 4'h1;
        end
      end
      default: fs_nxt = F_IDLE;
    endcase
    if (do_hdr) begin
      bcd = to_bcd({13'h0, fmt_count_i, 3'b000});
      nd = digit_count(bcd);
      buf_nxt[0] = CH_HASH;
      buf_nxt[1] = CH_ZERO + 8'(nd);
      for (int i = 7; i >= 0; i--) begin
        if (i < nd) buf_nxt[2 + nd - 1 - i] = CH_ZERO | {4'h0, bcd[i*4 +: 4]};
      end
      n = nd + 2;
    end else if (do_val && bin_r) begin
      word = {val_sign_i, val_exp_i, val_frac_i};
      for (int i = 0; i < BIN_VALUE_BYTES; i++) begin
        buf_nxt[i] = word[63 - 8*i -: 8];
      end
      n = BIN_VALUE_BYTES;
    end else if (do_val) begin
      bcd = to_bcd(val_mant_i);
      nd = digit_count(bcd);
      if (val_sign_i) begin
        buf_nxt[0] = CH_MINUS;
        n = 1;
      end
      if (form_r == FORM_NR2 && val_dexp_i < 0) begin
        p = -int'(val_dexp_i);
        if (p > 7) p = 7;
        if (nd < p + 1) nd = p + 1;
      end
      for (int i = 7; i >= 0; i--) begin
        if (i < nd) begin
          buf_nxt[n] = CH_ZERO | {4'h0, bcd[i*4 +: 4]};
          n = n + 1;
          if ((form_r == FORM_NR2 && p != 0 && i == p) || (form_r == FORM_NR3 && i == nd - 1)) begin
            buf_nxt[n] = CH_POINT;
            n = n + 1;
            if (form_r == FORM_NR3 && nd == 1) begin
              buf_nxt[n] = CH_ZERO;
              n = n + 1;
            end
          end
        end
      end
      if (form_r == FORM_NR3) begin
        x = int'(val_dexp_i) + nd - 1;
        buf_nxt[n] = CH_EXP;
        buf_nxt[n + 1] = (x < 0) ? CH_MINUS : CH_PLUS;
        if (x < 0) x = -x;
        if (x > 99) x = 99;
        buf_nxt[n + 2] = CH_ZERO + 8'(x / 10);
        buf_nxt[n + 3] = CH_ZERO + 8'(x % 10);
        n = n + 4;
      end
      if (left_r > 8'h01) begin
        buf_nxt[n] = CH_COMMA;
        n = n + 1;
      end
    end else if (do_term) begin
      buf_nxt[0] = CH_NL;
      n = 1;
      last_nxt = 1'b1;
    end
    if (do_hdr || do_val || do_term) begin
      len_nxt = 5'(n);
      idx_nxt = 4'h0;
      fs_nxt = F_EMIT;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      fs_r   <= F_IDLE;
      len_r  <= 5'h01;
      idx_r  <= 4'h0;
      left_r <= 8'h00;
      bin_r  <= 1'b0;
      form_r <= FORM_NR1;
      last_r <= 1'b0;
      for (int i = 0; i < BUF_BYTES; i++) buf_r[i] <= 8'h00;
    end else begin
      fs_r   <= fs_nxt;
      len_r  <= len_nxt;
      idx_r  <= idx_nxt;
      left_r <= left_nxt;
      bin_r  <= bin_nxt;
      form_r <= form_nxt;
      last_r <= last_nxt;
      buf_r  <= buf_nxt;
    end
  end

  assign val_ready_o = (fs_r == F_WAIT);
  assign out_valid_o = (fs_r == F_EMIT);
  assign out_data_o  = buf_r[idx_r];
  assign out_end_o   = (fs_r == F_EMIT) && last_r && ({1'b0, idx_r} == len_r - 5'h01);
  assign fmt_busy_o  = (fs_r != F_IDLE);
endmodule

// ### dv/sts_monitor.sv
// Concurrent checks on the ports of the status and trigger core.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/1ps
module sts_monitor
  import sts_pkg::*;
(
  input wire logic        clk_sys_i,
  input wire logic        reset_i,
  input wire logic        settling_i,
  input wire logic        ranging_i,
  input wire logic        correcting_i,
  input wire logic        first_result_buffer_full_i,
  input wire logic        second_result_buffer_full_i,
  input wire logic        oper_event_rd_i,
  input wire logic        fmt_start_i,
  input wire logic        fmt_binary_i,
  input wire logic        fmt_busy_o,
  input wire logic        meas_start_o,
  input wire logic        out_valid_o,
  input wire logic        out_end_o,
  input wire logic [7:0]  out_data_o,
  input wire logic [15:0] operation_condition_o,
  input wire logic [15:0] operation_event_o,
  input wire logic [15:0] operation_enable_o,
  input wire logic [15:0] questionable_status_o,
  input wire logic        stb_oper_summary_o,
  input wire logic        stb_ques_summary_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  sequence bin_start;
    fmt_start_i && !fmt_busy_o && fmt_binary_i;
  endsequence
  sequence hash_out;
    out_valid_o && out_data_o == CH_HASH;
  endsequence
  ques_zero_a: assert property (questionable_status_o == 16'h0000 && !stb_ques_summary_o)
    else $error("questionable group not zero");
  reserved_zero_a: assert property (
    ((operation_condition_o | operation_event_o) & ~OPER_IMPL_MASK) == 16'h0000)
    else $error("reserved status bit set");
  cond_track_a: assert property (!$past(reset_i) |->
    operation_condition_o[9:7] == $past({second_result_buffer_full_i, first_result_buffer_full_i, correcting_i})
    && operation_condition_o[2:1] == $past({ranging_i, settling_i}))
    else $error("condition bits do not follow inputs");
  fall_event_a: assert property ($fell(operation_condition_o[2]) |-> operation_event_o[2])
    else $error("falling edge not latched");
  no_rise_a: assert property (
    $rose(operation_condition_o[2]) && !$past(operation_event_o[2]) |-> !operation_event_o[2])
    else $error("rising edge latched on falling-edge bit");
  rise_event_a: assert property ($rose(operation_condition_o[9]) |-> operation_event_o[9])
    else $error("rising edge not latched");
  summary_or_a: assert property (stb_oper_summary_o == |(operation_event_o & operation_enable_o))
    else $error("summary mismatch");
  event_clear_a: assert property (
    oper_event_rd_i ##1 $stable(operation_condition_o) |-> operation_event_o == 16'h0000)
    else $error("event not cleared by read");
  start_pulse_a: assert property (meas_start_o |=> !meas_start_o)
    else $error("start longer than one cycle");
  bin_hash_a: assert property (bin_start |-> ##[1:8] hash_out)
    else $error("binary block lacks leading hash");
  end_nl_a: assert property (out_end_o |-> out_valid_o && out_data_o == CH_NL)
    else $error("end not on newline byte");
endmodule
bind sts_sequencer sts_monitor u_mon (.clk_sys_i, .reset_i, .settling_i, .ranging_i, .correcting_i,
  .first_result_buffer_full_i, .second_result_buffer_full_i, .oper_event_rd_i, .fmt_start_i, .fmt_binary_i,
  .fmt_busy_o, .meas_start_o, .out_valid_o, .out_end_o, .out_data_o, .operation_condition_o,
  .operation_event_o, .operation_enable_o, .questionable_status_o, .stb_oper_summary_o, .stb_ques_summary_o);

// ### dv/sts_host_model.sv
// Far-side model: measurement engine completion and response reader.
// Assumes the core's clock and reset; drives just after the rising edge.
`timescale 1ns/1ps
module sts_host_model (
  input  wire logic clk_sys_i,
  input  wire logic reset_i,
  input  wire logic meas_start_i,
  input  wire logic slow_i,
  output logic      meas_done_o,
  output logic      out_ready_o
);
  logic [3:0] cnt_r;
  logic [1:0] phase_r;
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      cnt_r <= 4'h0;
      phase_r <= 2'h0;
      meas_done_o <= 1'h0;
      out_ready_o <= 1'h0;
    end else begin
      phase_r <= phase_r + 2'h1;
      // Slow reader accepts one byte in four
      out_ready_o <= !slow_i || phase_r == 2'h0;
      meas_done_o <= cnt_r == 4'h1;
      if (meas_start_i) cnt_r <= 4'h6;
      else if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
    end
  end
endmodule

// ### dv/status_trigger_sequencer_bench.sv
// Self-checking bench for the status, trigger and formatter core.
// Assumes sts_host_model as far side and the bound port checker.
`timescale 1ns/1ps
module status_trigger_sequencer_bench
  import sts_pkg::*;
;
  logic clk_sys_i = '0, reset_i = '1, slow = '0, hit;
  logic cmd_abort_i = '0, cmd_reset_i = '0, cmd_init_imm_i = '0, cmd_init_cont_wr_i = '0, cmd_init_cont_val_i = '0;
  logic cmd_trig_imm_i = '0, cmd_bus_trig_i = '0, cmd_src_wr_i = '0, cmd_delay_wr_i = '0, ext_trig_i = '0;
  logic oper_enable_wr_i = '0, oper_event_rd_i = '0, fmt_start_i = '0, fmt_binary_i = '0, val_valid_i = '0;
  logic val_sign_i = '0, settling_i, ranging_i, correcting_i, first_result_buffer_full_i, second_result_buffer_full_i;
  logic [1:0] cmd_src_val_i = '0, fmt_form_i = '0;
  logic [4:0] cnd = '0;
  logic [7:0] fmt_count_i = '0, out_data_o;
  logic [10:0] val_exp_i = '0;
  logic [15:0] cmd_delay_val_i = '0, oper_enable_data_i = '0;
  logic [15:0] operation_condition_o, operation_event_o, operation_enable_o, questionable_status_o;
  logic [23:0] val_mant_i = '0;
  logic [51:0] val_frac_i = '0;
  logic signed [7:0] val_dexp_i = '0;
  logic meas_done_i, out_ready_i, val_ready_o, out_valid_o, out_end_o, fmt_busy_o, meas_start_o;
  logic stb_oper_summary_o, stb_ques_summary_o;
  logic [7:0] q[$];
  int err_count = 0, checks = 0, cyc = 0, n, end_cnt = 0;
  assign {second_result_buffer_full_i, first_result_buffer_full_i, correcting_i, ranging_i, settling_i} = cnd;
  sts_sequencer dut (.*);
  sts_host_model host (.clk_sys_i, .reset_i, .meas_start_i(meas_start_o), .slow_i(slow),
    .meas_done_o(meas_done_i), .out_ready_o(out_ready_i));
  always #12.5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      give_verdict();
    end
  end
  always @(posedge clk_sys_i) begin
    if (out_valid_o === 1'h1 && out_ready_i === 1'h1) begin
      q.push_back(out_data_o);
      if (out_end_o === 1'h1) end_cnt++;
    end
  end
  task tick; @(posedge clk_sys_i); #1; endtask
  task automatic pulse(ref logic s); s = 1'h1; tick(); s = 1'h0; endtask
  task chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task chk_q(input logic [7:0] e[$]);
    chk(q.size(), e.size());
    foreach (e[i]) if (i < q.size()) chk(q[i], e[i]);
  endtask
  task automatic chk_str(input string s);
    logic [7:0] e[$];
    foreach (s[i]) e.push_back(s[i]);
    chk_q(e);
  endtask
  // Waits for a measurement start; a start already showing counts, and is stepped past
  task wait_ms(input int lim);
    n = 0;
    while (meas_start_o !== 1'h1 && n < lim) begin
      tick();
      n++;
    end
    hit = meas_start_o === 1'h1;
    if (hit) tick();
  endtask
  task send_val(input logic s, input logic [10:0] e, input logic [51:0] f, input logic [23:0] m,
                input logic signed [7:0] d);
    int k;
    {val_sign_i, val_exp_i, val_frac_i, val_mant_i, val_dexp_i} = {s, e, f, m, d};
    val_valid_i = 1'h1;
    for (k = 0; k < 200 && val_ready_o !== 1'h1; k++) tick();
    chk(val_ready_o, 1'h1);
    tick();
  endtask
  task fmt_run(input logic b, input logic [1:0] f, input logic [7:0] c);
    q.delete();
    end_cnt = 0;
    {fmt_binary_i, fmt_form_i, fmt_count_i} = {b, f, c};
    pulse(fmt_start_i);
  endtask
  task fmt_wait;
    val_valid_i = 1'h0;
    for (n = 0; n < 400 && fmt_busy_o !== 1'h0; n++) tick();
    chk(fmt_busy_o, 1'h0);
    repeat (2) tick();
    chk(end_cnt, 1);
  endtask
  task t_reset;
    chk(operation_condition_o, 16'h0000);
    chk({questionable_status_o, stb_ques_summary_o}, 17'h00000);
    $display("reset test done");
  endtask
  task t_status;
    cnd = 5'h1F;
    repeat (2) tick();
    chk(operation_condition_o, 16'h0386);
    chk(operation_event_o, 16'h0300);
    pulse(oper_event_rd_i);
    tick();
    chk(operation_event_o, 16'h0000);
    oper_enable_data_i = 16'h0004;
    pulse(oper_enable_wr_i);
    chk(operation_enable_o, 16'h0004);
    cnd = 5'h00;
    repeat (2) tick();
    chk(operation_event_o, 16'h0086);
    chk(stb_oper_summary_o, 1'h1);
    pulse(oper_event_rd_i);
    tick();
    chk(stb_oper_summary_o, 1'h0);
    $display("status test done");
  endtask
  task t_trig;
    wait_ms(20);
    chk(hit, 1'h0);
    pulse(cmd_init_imm_i);
    wait_ms(10);
    chk(hit, 1'h1);
    tick();
    chk(operation_condition_o[BIT_MEASURING], 1'h1);
    wait_ms(60);
    chk(hit, 1'h0);
    chk(operation_condition_o[BIT_MEASURING], 1'h0);
    cmd_src_val_i = 2'h1;
    pulse(cmd_src_wr_i);
    cmd_init_cont_val_i = 1'h1;
    pulse(cmd_init_cont_wr_i);
    wait_ms(40);
    chk({hit, operation_condition_o[BIT_WAIT_TRIG]}, 2'h1);
    pulse(cmd_bus_trig_i);
    wait_ms(5);
    chk(hit, 1'h1);
    wait_ms(40);
    chk({hit, operation_condition_o[BIT_WAIT_TRIG]}, 2'h1);
    cmd_src_val_i = 2'h2;
    pulse(cmd_src_wr_i);
    pulse(cmd_bus_trig_i);
    wait_ms(20);
    chk(hit, 1'h0);
    ext_trig_i = 1'h1;
    wait_ms(5);
    chk(hit, 1'h1);
    ext_trig_i = 1'h0;
    $display("trigger test done");
  endtask
  task t_delay;
    repeat (20) tick();
    cmd_src_val_i = 2'h1;
    pulse(cmd_src_wr_i);
    cmd_delay_val_i = 16'h0002;
    pulse(cmd_delay_wr_i);
    pulse(cmd_bus_trig_i);
    wait_ms(300);
    chk(n >= 2 * DELAY_UNIT_CYC - 2 && n <= 2 * DELAY_UNIT_CYC + 6, 1'h1);
    repeat (20) tick();
    pulse(cmd_trig_imm_i);
    wait_ms(5);
    chk(hit, 1'h1);
    repeat (20) tick();
    pulse(cmd_bus_trig_i);
    repeat (10) tick();
    pulse(cmd_abort_i);
    wait_ms(150);
    chk(hit, 1'h0);
    pulse(cmd_reset_i);
    wait_ms(20);
    chk({hit, operation_condition_o[BIT_WAIT_TRIG]}, 2'h0);
    cmd_src_val_i = 2'h0;
    pulse(cmd_src_wr_i);
    pulse(cmd_init_imm_i);
    wait_ms(10);
    chk(hit, 1'h1);
    $display("delay test done");
  endtask
  task t_format;
    slow = 1'h1;
    fmt_run(1'h1, 2'h0, 8'h01);
    send_val(1'h1, 11'h400, 52'h8000000000000, 24'h000000, 8'sh00);
    fmt_wait();
    chk_q('{8'h23, 8'h31, 8'h38, 8'hC0, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0A});
    slow = 1'h0;
    fmt_run(1'h0, 2'h0, 8'h02);
    send_val(1'h0, 11'h000, 52'h0, 24'h000005, 8'sh00);
    send_val(1'h1, 11'h000, 52'h0, 24'h00000C, 8'sh00);
    fmt_wait();
    chk_str("5,-12\n");
    fmt_run(1'h0, 2'h1, 8'h01);
    send_val(1'h0, 11'h000, 52'h0, 24'h00007D, -8'sh02);
    fmt_wait();
    chk_str("1.25\n");
    fmt_run(1'h0, 2'h2, 8'h01);
    send_val(1'h0, 11'h000, 52'h0, 24'h000005, 8'sh00);
    fmt_wait();
    chk({q[0], q[1], q[$]}, {8'h35, CH_POINT, CH_NL});
    $display("format test done");
  endtask
  task give_verdict;
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_sys_i);
    #1;
    reset_i = 1'h0;
    tick();
    t_reset();
    t_status();
    t_trig();
    t_delay();
    t_format();
    give_verdict();
  end
endmodule
